// [verilog/mesa_map_pkg.sv]
`default_nettype none
package mesa_map_pkg;
  typedef enum {
    ST_IDLE, ST_PARSE, ST_EXC, ST_RD_FETCH, ST_RD_TAKE,
    ST_WC_FETCH, ST_WC_TAKE, ST_WR_DO, ST_SEND, ST_SENDW
  } state_t;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BAUD_RATE = 38400;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam int RTU_GAP_NS = 1_750_000;
  localparam int RTU_GAP_CYCLES = (RTU_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Link settings
  localparam logic [7:0] DEFAULT_SLAVE = 8'h01;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  localparam logic [15:0] TCP_PORT = 16'h01f6;
  localparam int BUF_BYTES = 256;
  localparam logic [15:0] MAX_RD_QTY = 16'h007d;
  localparam logic [15:0] MAX_WR_QTY = 16'h007b;
  // Function and exception codes
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  localparam logic [7:0] EXC_WRITE_FAIL = 8'h04;
  // Map layout
  localparam logic [15:0] MAP_START = 16'h9c40;
  localparam logic [15:0] MARKER_HI = 16'h5375;
  localparam logic [15:0] MARKER_LO = 16'h6e53;
  localparam logic [15:0] COMMON_ID = 16'h0001;
  localparam logic [15:0] COMMON_LEN = 16'h0042;
  localparam logic [15:0] M801_BASE = 16'h9c86;
  localparam logic [15:0] M801_ID = 16'h0321;
  localparam logic [15:0] M801_LEN = 16'h0016;
  localparam logic [15:0] M802_BASE = 16'h9c9e;
  localparam logic [15:0] M802_ID = 16'h0322;
  localparam logic [15:0] M802_LEN = 16'h0014;
  localparam logic [15:0] M803_BASE = 16'h9cb4;
  localparam logic [15:0] M803_ID = 16'h0323;
  localparam logic [15:0] END_ID = 16'hffff;
  localparam logic [15:0] END_LEN = 16'h0000;
  localparam logic [15:0] ALARM_CLEAR_ADDR = 16'h9c98;
  // Point types reported by the point store, sentinel values and checksum constants
  localparam logic [2:0] PT_S16 = 3'h0;
  localparam logic [2:0] PT_U16 = 3'h1;
  localparam logic [2:0] PT_E16 = 3'h2;
  localparam logic [2:0] PT_S32 = 3'h3;
  localparam logic [2:0] PT_U32 = 3'h4;
  localparam logic [2:0] PT_E32 = 3'h5;
  localparam logic [15:0] SENT_SIGNED = 16'h8000;
  localparam logic [15:0] SENT_ONES = 16'hffff;
  localparam logic [15:0] SENT_ZERO = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
endpackage
`default_nettype wire

// [verilog/uart_rx_char.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_rx_char #(
  parameter int divisor = mesa_map_pkg::BAUD_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Line
  input wire logic rxdPin,
  // Received character
  output logic charValid,
  output logic [7:0] charData,
  output logic charError
);
  typedef struct packed {
    logic s1, s2, s3, lvl, busy, valid, err;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [9:0] sh;
    logic [7:0] data;
  } rx_t;
  rx_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.s1 = rxdPin;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // Glitches shorter than one clock never reach the filtered level
    if (s_r.s2 == s_r.s3) begin
      s_nxt.lvl = s_r.s3;
    end
    if (!s_r.busy) begin
      if (s_r.lvl && !s_nxt.lvl) begin
        s_nxt.busy = 1'b1;
        s_nxt.cnt = 16'(divisor / 2);
        s_nxt.bitn = 4'h0;
      end
    end else if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end else begin
      s_nxt.cnt = 16'(divisor - 1);
      s_nxt.bitn = s_r.bitn + 4'h1;
      if (s_r.bitn == 4'h0) begin
        if (s_r.lvl) begin
          s_nxt.busy = 1'b0;
        end
      end else begin
        s_nxt.sh = {s_r.lvl, s_r.sh[9:1]};
        if (s_r.bitn == 4'ha) begin
          s_nxt.busy = 1'b0;
          s_nxt.valid = 1'b1;
          s_nxt.data = s_nxt.sh[7:0];
          s_nxt.err = (^s_nxt.sh[8:0]) | !s_nxt.sh[9];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
      s_r.s1 <= 1'b1;
      s_r.s2 <= 1'b1;
      s_r.s3 <= 1'b1;
      s_r.lvl <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign charValid = s_r.valid;
  assign charData = s_r.data;
  assign charError = s_r.err;
endmodule // uart_rx_char
`default_nettype wire

// [verilog/uart_tx_char.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_tx_char #(
  parameter int divisor = mesa_map_pkg::BAUD_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Character to send
  input wire logic charStart,
  input wire logic [7:0] charData,
  output logic charBusy,
  // Line
  output logic txdPin
);
  typedef struct packed {
    logic busy, txd;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [10:0] sh;
  } tx_t;
  tx_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!s_r.busy) begin
      if (charStart) begin
        s_nxt.sh = {1'b1, ^charData, charData, 1'b0};
        s_nxt.busy = 1'b1;
        s_nxt.cnt = 16'(divisor - 1);
        s_nxt.bitn = 4'h0;
        s_nxt.txd = 1'b0;
      end
    end else if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end else if (s_r.bitn == 4'ha) begin
      s_nxt.busy = 1'b0;
      s_nxt.txd = 1'b1;
    end else begin
      s_nxt.sh = {1'b1, s_r.sh[10:1]};
      s_nxt.txd = s_r.sh[1];
      s_nxt.bitn = s_r.bitn + 4'h1;
      s_nxt.cnt = 16'(divisor - 1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign charBusy = s_r.busy;
  assign txdPin = s_r.txd;
endmodule // uart_tx_char
`default_nettype wire

// [verilog/mesa_register_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module mesa_register_slave #(
  parameter int numStacks = 1,
  parameter int fixLen803 = 14,
  parameter int repLen803 = 26,
  parameter int gapCycles = mesa_map_pkg::RTU_GAP_CYCLES,
  parameter int baudDiv = mesa_map_pkg::BAUD_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Serial line
  input wire logic uartRxd,
  output logic uartTxd,
  output logic uartTxEn,
  // Slave address configuration
  input wire logic cfgClear,
  input wire logic cfgAddrLoad,
  input wire logic [7:0] cfgAddrValue,
  output logic slaveAddr,
  // Stack installation
  input wire logic [numStacks-1:0] stackInstalled,
  // Point store: answers combinationally to ptAddr
  output logic [15:0] ptAddr,
  input wire logic [15:0] ptData,
  input wire logic ptImpl,
  input wire logic [2:0] ptType,
  input wire logic ptWide,
  input wire logic ptHigh,
  input wire logic ptWritable,
  input wire logic ptIsScale,
  // Point writes
  output logic wrStrobe,
  output logic [15:0] wrAddr,
  output logic [15:0] wrData,
  // TCP session admission
  input wire logic tcpOpenReq,
  input wire logic [15:0] tcpOpenPort,
  input wire logic tcpCloseReq,
  output logic tcpAccept,
  output logic tcpReject,
  output logic tcpActive,
  output logic tcpWriteAllowed
);
  localparam int BUF = mesa_map_pkg::BUF_BYTES;
  localparam logic [15:0] LEN803 = 16'(fixLen803 + numStacks * repLen803);
  localparam logic [15:0] REP_BASE = 16'(mesa_map_pkg::M803_BASE + 16'h0002 + 16'(fixLen803));
  localparam logic [15:0] END_BASE = 16'(REP_BASE + 16'(numStacks * repLen803));
  localparam logic [1:0] MK_NONE = 2'h0;
  localparam logic [1:0] MK_CONST = 2'h1;
  localparam logic [1:0] MK_POINT = 2'h2;

  typedef struct packed {
    mesa_map_pkg::state_t st;
    logic [7:0] slave;
    logic [8:0] rxCnt;
    logic [BUF-1:0][7:0] rxBuf;
    logic [15:0] rxCrc;
    logic rxBad;
    logic [19:0] gapCnt;
    logic [BUF-1:0][7:0] txBuf;
    logic [8:0] txLen, txPos;
    logic [15:0] txCrc;
    logic [7:0] txByte;
    logic txGo, txEn;
    logic [7:0] fc, exc;
    logic bcast;
    logic [15:0] addr, qty;
    logic [6:0] idx;
    logic [15:0] ptAddr, wrAddr, wrData;
    logic wrStrobe;
    logic tcpActive, tcpAccept, tcpReject;
  } slave_t;
  slave_t s_r, s_nxt;

  logic rxValid, rxError, txBusy;
  logic [7:0] rxData;

  uart_rx_char #(.divisor(baudDiv)) rxUnit (
    .clock(clock),
    .srst(srst),
    .rxdPin(uartRxd),
    .charValid(rxValid),
    .charData(rxData),
    .charError(rxError)
  );

  uart_tx_char #(.divisor(baudDiv)) txUnit (
    .clock(clock),
    .srst(srst),
    .charStart(s_r.txGo),
    .charData(s_r.txByte),
    .charBusy(txBusy),
    .txdPin(uartTxd)
  );

  function automatic logic [15:0] crc16(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ mesa_map_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] sentinel(input logic [2:0] t, input logic high);
    logic [15:0] v;
    v = mesa_map_pkg::SENT_ONES;
    if (t == mesa_map_pkg::PT_S16) begin
      v = mesa_map_pkg::SENT_SIGNED;
    end else if (t == mesa_map_pkg::PT_S32) begin
      v = high ? mesa_map_pkg::SENT_SIGNED : mesa_map_pkg::SENT_ZERO;
    end
    return v;
  endfunction

  // Kind in [17:16], constant value in [15:0]
  function automatic logic [17:0] lookup(input logic [15:0] a, input logic [numStacks-1:0] inst);
    logic [17:0] r;
    int stack;
    r = {MK_NONE, 16'h0000};
    stack = 0;
    if (a == mesa_map_pkg::MAP_START) begin
      r = {MK_CONST, mesa_map_pkg::MARKER_HI};
    end else if (a == mesa_map_pkg::MAP_START + 16'h0001) begin
      r = {MK_CONST, mesa_map_pkg::MARKER_LO};
    end else if (a == mesa_map_pkg::MAP_START + 16'h0002) begin
      r = {MK_CONST, mesa_map_pkg::COMMON_ID};
    end else if (a == mesa_map_pkg::MAP_START + 16'h0003) begin
      r = {MK_CONST, mesa_map_pkg::COMMON_LEN};
    end else if (a == mesa_map_pkg::M801_BASE) begin
      r = {MK_CONST, mesa_map_pkg::M801_ID};
    end else if (a == mesa_map_pkg::M801_BASE + 16'h0001) begin
      r = {MK_CONST, mesa_map_pkg::M801_LEN};
    end else if (a == mesa_map_pkg::M802_BASE) begin
      r = {MK_CONST, mesa_map_pkg::M802_ID};
    end else if (a == mesa_map_pkg::M802_BASE + 16'h0001) begin
      r = {MK_CONST, mesa_map_pkg::M802_LEN};
    end else if (a == mesa_map_pkg::M803_BASE) begin
      r = {MK_CONST, mesa_map_pkg::M803_ID};
    end else if (a == mesa_map_pkg::M803_BASE + 16'h0001) begin
      r = {MK_CONST, LEN803};
    end else if (a == END_BASE) begin
      r = {MK_CONST, mesa_map_pkg::END_ID};
    end else if (a == END_BASE + 16'h0001) begin
      r = {MK_CONST, mesa_map_pkg::END_LEN};
    end else if (a >= REP_BASE && a < END_BASE) begin
      stack = int'(a - REP_BASE) / repLen803;
      if (inst[stack]) begin
        r = {MK_POINT, 16'h0000};
      end
    end else if (a > mesa_map_pkg::MAP_START && a < END_BASE) begin
      r = {MK_POINT, 16'h0000};
    end
    return r;
  endfunction

  logic [17:0] hit;
  logic lastReg, partial, canWrite;
  logic [15:0] rdValue;
  logic frameOk;

  always_comb begin
    hit = lookup(s_r.addr, stackInstalled);
    lastReg = ({9'h000, s_r.idx} == s_r.qty - 16'h0001);
    partial = (hit[17:16] == MK_POINT) && ptWide && ((s_r.idx == 7'h00 && !ptHigh) || (lastReg && ptHigh));
    canWrite = (hit[17:16] == MK_POINT) &&
      ((ptImpl && ptWritable && !ptIsScale) || s_r.addr == mesa_map_pkg::ALARM_CLEAR_ADDR);
    if (hit[17:16] == MK_CONST) begin
      rdValue = hit[15:0];
    end else if (s_r.addr == mesa_map_pkg::ALARM_CLEAR_ADDR) begin
      rdValue = mesa_map_pkg::SENT_ONES;
    end else if (ptImpl) begin
      rdValue = ptData;
    end else begin
      rdValue = sentinel(ptType, ptHigh);
    end
    frameOk = !s_r.rxBad && s_r.rxCnt >= 9'h004 && s_r.rxCrc == 16'h0000 &&
      (s_r.rxBuf[0] == s_r.slave || s_r.rxBuf[0] == mesa_map_pkg::BROADCAST_ADDR);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.txGo = 1'b0;
    s_nxt.wrStrobe = 1'b0;
    s_nxt.tcpAccept = 1'b0;
    s_nxt.tcpReject = 1'b0;
    if (cfgClear) begin
      s_nxt.slave = mesa_map_pkg::DEFAULT_SLAVE;
    end else if (cfgAddrLoad) begin
      s_nxt.slave = cfgAddrValue;
    end
    if (tcpCloseReq) begin
      s_nxt.tcpActive = 1'b0;
    end
    if (tcpOpenReq) begin
      // A second session is refused while one is open
      if (!s_r.tcpActive && tcpOpenPort == mesa_map_pkg::TCP_PORT) begin
        s_nxt.tcpActive = 1'b1;
        s_nxt.tcpAccept = 1'b1;
      end else begin
        s_nxt.tcpReject = 1'b1;
      end
    end
    unique case (s_r.st)
      mesa_map_pkg::ST_IDLE: begin
        s_nxt.txEn = 1'b0;
        if (rxValid) begin
          if (s_r.rxCnt < 9'(BUF)) begin
            s_nxt.rxBuf[s_r.rxCnt[7:0]] = rxData;
            s_nxt.rxCnt = s_r.rxCnt + 9'h001;
          end else begin
            s_nxt.rxBad = 1'b1;
          end
          s_nxt.rxBad = s_nxt.rxBad | rxError;
          s_nxt.rxCrc = crc16(s_r.rxCrc, rxData);
          s_nxt.gapCnt = 20'h00000;
        end else if (s_r.rxCnt != 9'h000) begin
          if (s_r.gapCnt >= 20'(gapCycles - 1)) begin
            s_nxt.st = mesa_map_pkg::ST_PARSE;
          end else begin
            s_nxt.gapCnt = s_r.gapCnt + 20'h00001;
          end
        end
      end
      mesa_map_pkg::ST_PARSE: begin
        s_nxt.rxCnt = 9'h000;
        s_nxt.rxCrc = mesa_map_pkg::CRC_INIT;
        s_nxt.rxBad = 1'b0;
        s_nxt.gapCnt = 20'h00000;
        s_nxt.st = mesa_map_pkg::ST_IDLE;
        s_nxt.bcast = (s_r.rxBuf[0] == mesa_map_pkg::BROADCAST_ADDR);
        s_nxt.fc = s_r.rxBuf[1];
        s_nxt.addr = {s_r.rxBuf[2], s_r.rxBuf[3]};
        s_nxt.qty = {s_r.rxBuf[4], s_r.rxBuf[5]};
        s_nxt.idx = 7'h00;
        s_nxt.txBuf[0] = s_r.slave;
        s_nxt.txLen = 9'h000;
        if (frameOk) begin
          s_nxt.st = mesa_map_pkg::ST_EXC;
          s_nxt.exc = mesa_map_pkg::EXC_ILL_VALUE;
          if (s_r.rxBuf[1] == mesa_map_pkg::FC_READ_HOLD) begin
            if (s_nxt.bcast) begin
              s_nxt.st = mesa_map_pkg::ST_IDLE;
            end else if (s_r.rxCnt == 9'h008 && s_nxt.qty != 16'h0000 && s_nxt.qty <= mesa_map_pkg::MAX_RD_QTY) begin
              s_nxt.txBuf[1] = s_r.rxBuf[1];
              s_nxt.txBuf[2] = {s_nxt.qty[6:0], 1'b0};
              s_nxt.txLen = 9'h003;
              s_nxt.st = mesa_map_pkg::ST_RD_FETCH;
            end
          end else if (s_r.rxBuf[1] == mesa_map_pkg::FC_WRITE_ONE) begin
            s_nxt.qty = 16'h0001;
            if (s_r.rxCnt == 9'h008) begin
              s_nxt.st = mesa_map_pkg::ST_WC_FETCH;
            end
          end else if (s_r.rxBuf[1] == mesa_map_pkg::FC_WRITE_MANY) begin
            if (s_nxt.qty != 16'h0000 && s_nxt.qty <= mesa_map_pkg::MAX_WR_QTY &&
                s_r.rxBuf[6] == {s_nxt.qty[6:0], 1'b0} && s_r.rxCnt == 9'(9 + 2 * s_nxt.qty[6:0])) begin
              s_nxt.st = mesa_map_pkg::ST_WC_FETCH;
            end
          end else begin
            s_nxt.exc = mesa_map_pkg::EXC_ILL_FUNC;
          end
        end
      end
      mesa_map_pkg::ST_EXC: begin
        s_nxt.txBuf[1] = s_r.fc | mesa_map_pkg::FC_EXC_FLAG;
        s_nxt.txBuf[2] = s_r.exc;
        s_nxt.txLen = 9'h003;
        s_nxt.st = s_r.bcast ? mesa_map_pkg::ST_IDLE : mesa_map_pkg::ST_SEND;
      end
      mesa_map_pkg::ST_RD_FETCH: begin
        s_nxt.ptAddr = s_r.addr;
        s_nxt.st = mesa_map_pkg::ST_RD_TAKE;
      end
      mesa_map_pkg::ST_RD_TAKE: begin
        if (hit[17:16] == MK_NONE) begin
          s_nxt.exc = mesa_map_pkg::EXC_ILL_ADDR;
          s_nxt.st = mesa_map_pkg::ST_EXC;
        end else if (partial) begin
          s_nxt.exc = mesa_map_pkg::EXC_ILL_ADDR;
          s_nxt.st = mesa_map_pkg::ST_EXC;
        end else begin
          s_nxt.txBuf[8'(3 + 2 * s_r.idx)] = rdValue[15:8];
          s_nxt.txBuf[8'(4 + 2 * s_r.idx)] = rdValue[7:0];
          s_nxt.txLen = s_r.txLen + 9'h002;
          s_nxt.addr = s_r.addr + 16'h0001;
          s_nxt.idx = s_r.idx + 7'h01;
          s_nxt.st = lastReg ? mesa_map_pkg::ST_SEND : mesa_map_pkg::ST_RD_FETCH;
        end
      end
      mesa_map_pkg::ST_WC_FETCH: begin
        s_nxt.ptAddr = s_r.addr;
        s_nxt.st = mesa_map_pkg::ST_WC_TAKE;
      end
      mesa_map_pkg::ST_WC_TAKE: begin
        // Whole request is checked before any register is touched
        if (hit[17:16] == MK_NONE) begin
          s_nxt.exc = mesa_map_pkg::EXC_ILL_ADDR;
          s_nxt.st = mesa_map_pkg::ST_EXC;
        end else if (partial || !canWrite) begin
          s_nxt.exc = mesa_map_pkg::EXC_WRITE_FAIL;
          s_nxt.st = mesa_map_pkg::ST_EXC;
        end else if (lastReg) begin
          s_nxt.addr = {s_r.rxBuf[2], s_r.rxBuf[3]};
          s_nxt.idx = 7'h00;
          s_nxt.st = mesa_map_pkg::ST_WR_DO;
        end else begin
          s_nxt.addr = s_r.addr + 16'h0001;
          s_nxt.idx = s_r.idx + 7'h01;
          s_nxt.st = mesa_map_pkg::ST_WC_FETCH;
        end
      end
      mesa_map_pkg::ST_WR_DO: begin
        s_nxt.wrStrobe = 1'b1;
        s_nxt.wrAddr = s_r.addr;
        if (s_r.fc == mesa_map_pkg::FC_WRITE_ONE) begin
          s_nxt.wrData = {s_r.rxBuf[4], s_r.rxBuf[5]};
        end else begin
          s_nxt.wrData = {s_r.rxBuf[8'(7 + 2 * s_r.idx)], s_r.rxBuf[8'(8 + 2 * s_r.idx)]};
        end
        s_nxt.addr = s_r.addr + 16'h0001;
        s_nxt.idx = s_r.idx + 7'h01;
        if (lastReg) begin
          s_nxt.txBuf[1] = s_r.fc;
          for (int i = 2; i < 6; i++) begin
            s_nxt.txBuf[i] = s_r.rxBuf[i];
          end
          s_nxt.txLen = 9'h006;
          s_nxt.st = s_r.bcast ? mesa_map_pkg::ST_IDLE : mesa_map_pkg::ST_SEND;
        end
      end
      mesa_map_pkg::ST_SEND: begin
        s_nxt.txEn = 1'b1;
        if (!txBusy) begin
          if (s_r.txPos == s_r.txLen + 9'h002) begin
            s_nxt.txPos = 9'h000;
            s_nxt.txCrc = mesa_map_pkg::CRC_INIT;
            s_nxt.st = mesa_map_pkg::ST_IDLE;
          end else begin
            // Checksum goes low byte first, unlike register data
            if (s_r.txPos < s_r.txLen) begin
              s_nxt.txByte = s_r.txBuf[s_r.txPos[7:0]];
              s_nxt.txCrc = crc16(s_r.txCrc, s_r.txBuf[s_r.txPos[7:0]]);
            end else if (s_r.txPos == s_r.txLen) begin
              s_nxt.txByte = s_r.txCrc[7:0];
            end else begin
              s_nxt.txByte = s_r.txCrc[15:8];
            end
            s_nxt.txGo = 1'b1;
            s_nxt.txPos = s_r.txPos + 9'h001;
            s_nxt.st = mesa_map_pkg::ST_SENDW;
          end
        end
      end
      mesa_map_pkg::ST_SENDW: begin
        s_nxt.txEn = 1'b1;
        s_nxt.st = mesa_map_pkg::ST_SEND;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r <= '0;
      s_r.st <= mesa_map_pkg::ST_IDLE;
      s_r.slave <= mesa_map_pkg::DEFAULT_SLAVE;
      s_r.rxCrc <= mesa_map_pkg::CRC_INIT;
      s_r.txCrc <= mesa_map_pkg::CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign uartTxEn = s_r.txEn;
  assign slaveAddr = s_r.slave[0];
  assign ptAddr = s_r.ptAddr;
  assign wrStrobe = s_r.wrStrobe;
  assign wrAddr = s_r.wrAddr;
  assign wrData = s_r.wrData;
  assign tcpAccept = s_r.tcpAccept;
  assign tcpReject = s_r.tcpReject;
  assign tcpActive = s_r.tcpActive;
  assign tcpWriteAllowed = s_r.tcpActive;
endmodule // mesa_register_slave
`default_nettype wire

// [tb/mesa_slave_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module mesa_slave_assertions (
  // Clock, reset and watched ports
  input wire logic clock, srst, uartTxd, uartTxEn, cfgClear, cfgAddrLoad, slaveAddr,
  input wire logic [7:0] cfgAddrValue,
  input wire logic [15:0] tcpOpenPort,
  input wire logic tcpOpenReq, tcpCloseReq, tcpAccept, tcpReject, tcpActive, tcpWriteAllowed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_acc; tcpOpenReq && !tcpActive && tcpOpenPort == 16'h01f6 |=> tcpAccept && tcpActive; endproperty
  a_acc: assert property (p_acc) else $error("open not accepted");
  property p_busy; tcpOpenReq && tcpActive && !tcpCloseReq |=> tcpReject && !tcpAccept; endproperty
  a_busy: assert property (p_busy) else $error("second session let in");
  property p_port; tcpOpenReq && tcpOpenPort != 16'h01f6 |=> tcpReject && !tcpAccept; endproperty
  a_port: assert property (p_port) else $error("foreign port let in");
  property p_wr; tcpWriteAllowed == tcpActive; endproperty
  a_wr: assert property (p_wr) else $error("session without write access");
  property p_hold; tcpActive && !tcpCloseReq |=> tcpActive; endproperty
  a_hold: assert property (p_hold) else $error("session dropped");
  // A start bit with the driver still off would never reach the master
  property p_line; $fell(uartTxd) |-> ##[0:2] uartTxEn; endproperty
  a_line: assert property (p_line) else $error("line active while driver off");
  property p_clr; cfgClear |=> slaveAddr; endproperty
  a_clr: assert property (p_clr) else $error("address not back to one");
  property p_load; cfgAddrLoad && !cfgClear |=> slaveAddr == $past(cfgAddrValue[0]); endproperty
  a_load: assert property (p_load) else $error("address not loaded");
endmodule // mesa_slave_assertions
`default_nettype wire

// [tb/point_store_model.sv]
`timescale 1ns/1ps
`default_nettype none
module point_store_model (
  // Lookup address
  input wire logic [15:0] ptAddr,
  // Answer
  output logic [15:0] ptData,
  output logic [2:0] ptType,
  output logic ptImpl, ptWide, ptHigh, ptWritable, ptIsScale
);
  // Odd addresses play the points left unimplemented, so sentinels show up
  assign ptImpl = !ptAddr[0];
  assign ptData = ~ptAddr;
  assign ptType = mesa_map_pkg::PT_S16;
  assign ptWide = 1'b0;
  assign ptHigh = 1'b0;
  assign ptWritable = 1'b1;
  // No scale factor points here, so none can drift
  assign ptIsScale = 1'b0;
endmodule // point_store_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, srst = 1, uartRxd = 1, cfgClear = 0, cfgAddrLoad = 0, tcpOpenReq = 0, tcpCloseReq = 0;
  logic [7:0] cfgAddrValue = 8'h01;
  logic [15:0] tcpOpenPort = 16'h0000;
  logic [0:0] stackInstalled = 1'b1;
  logic [15:0] ptAddr, ptData, wrAddr, wrData;
  logic [2:0] ptType;
  logic uartTxd, uartTxEn, slaveAddr, ptImpl, ptWide, ptHigh, ptWritable, ptIsScale, wrStrobe;
  logic tcpAccept, tcpReject, tcpActive, tcpWriteAllowed;
  int error_cnt = 0, checks = 0, tcpModel = 0, wrSeen = 0;
  logic [31:0] expWr = '0;
  // Short bit time keeps the run small; the frame gap must outlast one character
  localparam int DIV = 32;
  mesa_register_slave #(.gapCycles(4 * 11 * DIV), .baudDiv(DIV)) dut_u (.clock, .srst, .uartRxd, .uartTxd,
    .uartTxEn, .cfgClear,
    .cfgAddrLoad, .cfgAddrValue, .slaveAddr, .stackInstalled, .ptAddr, .ptData, .ptImpl, .ptType, .ptWide,
    .ptHigh, .ptWritable, .ptIsScale, .wrStrobe, .wrAddr, .wrData, .tcpOpenReq, .tcpOpenPort, .tcpCloseReq,
    .tcpAccept, .tcpReject, .tcpActive, .tcpWriteAllowed);
  point_store_model store_u (.ptAddr, .ptData, .ptImpl, .ptType, .ptWide, .ptHigh, .ptWritable, .ptIsScale);
  initial begin
    forever #50 clock = ~clock;
  end
  function automatic logic [15:0] crc16(byte unsigned b[$]);
    logic [15:0] c = mesa_map_pkg::CRC_INIT;
    foreach (b[i]) begin
      c ^= 16'(b[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ mesa_map_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask
  always @(negedge clock) begin
    if (wrStrobe === 1'b1) begin
      wrSeen++;
      chk("write address", expWr[31:16], wrAddr);
      chk("write data", expWr[15:0], wrData);
    end
  end
  task automatic xfer(byte unsigned req[$], byte unsigned rsp[$]);
    logic [15:0] c;
    logic [10:0] ch;
    int w;
    cyc(200);
    req.push_front(mesa_map_pkg::DEFAULT_SLAVE);
    rsp.push_front(mesa_map_pkg::DEFAULT_SLAVE);
    c = crc16(req);
    req = {req, c[7:0], c[15:8]};
    c = crc16(rsp);
    rsp = {rsp, c[7:0], c[15:8]};
    foreach (req[i]) begin
      ch = {1'b1, ^req[i], req[i], 1'b0};
      for (int k = 0; k < 11; k++) begin
        uartRxd <= ch[k];
        cyc(DIV);
      end
    end
    // Sampling mid-bit on the falling clock keeps clear of the transmit flop
    foreach (rsp[i]) begin
      w = 0;
      while (uartTxd !== 1'b0 && w < 40000) begin
        @(negedge clock);
        w++;
      end
      repeat (DIV / 2) @(negedge clock);
      for (int k = 0; k < 11; k++) begin
        ch[k] = uartTxd;
        if (k < 10) repeat (DIV) @(negedge clock);
      end
      chk("response char", {5'h00, 1'b1, ^rsp[i], rsp[i], 1'b0}, {5'h00, ch});
    end
  endtask
  task automatic rd(logic [15:0] addr, int qty, logic [15:0] v[$], logic [7:0] exc);
    byte unsigned req[$], rsp[$];
    req = {mesa_map_pkg::FC_READ_HOLD, addr[15:8], addr[7:0], 8'h00, 8'(qty)};
    rsp = {mesa_map_pkg::FC_READ_HOLD, 8'(2 * qty)};
    foreach (v[i]) rsp = {rsp, v[i][15:8], v[i][7:0]};
    if (exc != 8'h00) rsp = {mesa_map_pkg::FC_READ_HOLD | mesa_map_pkg::FC_EXC_FLAG, exc};
    xfer(req, rsp);
  endtask
  task automatic wr(logic [15:0] addr, logic [15:0] d, logic [7:0] exc);
    byte unsigned req[$], rsp[$];
    int w0;
    req = {mesa_map_pkg::FC_WRITE_ONE, addr[15:8], addr[7:0], d[15:8], d[7:0]};
    rsp = req;
    if (exc != 8'h00) rsp = {mesa_map_pkg::FC_WRITE_ONE | mesa_map_pkg::FC_EXC_FLAG, exc};
    expWr = {addr, d};
    w0 = wrSeen;
    xfer(req, rsp);
    chk("write count", 16'(exc == 8'h00), 16'(wrSeen - w0));
  endtask
  task automatic tcp(logic [15:0] port, logic close);
    logic acc;
    cyc(1);
    acc = tcpModel == 0 && port == mesa_map_pkg::TCP_PORT;
    if (acc) tcpModel = 1;
    else if (close) tcpModel = 0;
    tcpOpenReq <= 1'b1;
    tcpOpenPort <= port;
    tcpCloseReq <= close;
    cyc(1);
    tcpOpenReq <= 1'b0;
    tcpCloseReq <= 1'b0;
    @(negedge clock);
    chk("tcp accept", 16'(acc), {15'h0000, tcpAccept});
    chk("tcp reject", 16'(!acc), {15'h0000, tcpReject});
    chk("tcp active", 16'(tcpModel), {15'h0000, tcpActive});
  endtask
  task automatic results;
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h61455dea));
    cyc(20);
    srst <= 1'b0;
    rd(mesa_map_pkg::M801_BASE, 1, '{mesa_map_pkg::M801_ID}, 8'h00);
    rd(mesa_map_pkg::ALARM_CLEAR_ADDR, 2, '{16'hffff, mesa_map_pkg::SENT_SIGNED}, 8'h00);
    wr(mesa_map_pkg::ALARM_CLEAR_ADDR, 16'($urandom), 8'h00);
    wr(mesa_map_pkg::ALARM_CLEAR_ADDR + 16'h0001, 16'($urandom), mesa_map_pkg::EXC_WRITE_FAIL);
    // Header, 14 fixed and one block of 26: the last block register sits just before the end model
    rd(mesa_map_pkg::M803_BASE + 16'd41, 3, '{16'h8000, mesa_map_pkg::END_ID, mesa_map_pkg::END_LEN}, 8'h00);
    @(posedge clock) stackInstalled <= 1'b0;
    rd(mesa_map_pkg::M803_BASE + 16'd41, 1, '{16'h0000}, mesa_map_pkg::EXC_ILL_ADDR);
    tcp(mesa_map_pkg::TCP_PORT, 1'b0);
    tcp(mesa_map_pkg::TCP_PORT, 1'b0);
    tcp(16'($urandom_range(1, 501)), 1'b1);
    tcp(mesa_map_pkg::TCP_PORT, 1'b1);
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      // Zero stays out: it would turn the device into a broadcast listener
      cfgAddrValue <= 8'($urandom_range(1, 255));
      cfgAddrLoad <= 1'b1;
      cfgClear <= i[0];
      cyc(1);
      cfgAddrLoad <= 1'b0;
      cfgClear <= 1'b0;
      @(negedge clock);
      chk("slave address", i[0] ? 16'h0001 : {15'h0000, cfgAddrValue[0]}, {15'h0000, slaveAddr});
    end
    results;
  end
  initial begin
    // Roughly twice the expected length of the run
    #(90_000 * 100);
    error_cnt++;
    results;
  end
endmodule // tb_top
bind mesa_register_slave mesa_slave_assertions chk_u (.clock, .srst, .uartTxd, .uartTxEn, .cfgClear, .cfgAddrLoad,
  .slaveAddr, .cfgAddrValue, .tcpOpenPort, .tcpOpenReq, .tcpCloseReq, .tcpAccept, .tcpReject, .tcpActive,
  .tcpWriteAllowed);
`default_nettype wire
